// File: shared/tedm_pkg.sv
/*
 * Constants and types of the tooth edge decision block.
 * Assumes a 125 MHz system clock and one 32-bit register word per offset.
 */
`default_nettype none
package tedm_pkg;
	// Operating modes of the decision logic
	typedef enum logic [1:0] {MODE_POWERON, MODE_STARTUP, MODE_CALIB, MODE_RUN} tedm_mode_t;

	// Register byte offsets
	localparam logic [7:0] REG_CTRL   = 8'h00;
	localparam logic [7:0] REG_STATUS = 8'h04;
	localparam logic [7:0] REG_PKPK   = 8'h08;
	localparam logic [7:0] REG_THR    = 8'h0C;

	// Control fields and reset values
	localparam int   CTRL_ENABLE_POS  = 0;
	localparam int   CTRL_RELEARN_POS = 1;
	localparam logic CTRL_ENABLE_RST  = 1'b1;

	// Status field positions
	localparam int ST_MODE_POS  = 0;
	localparam int ST_OUT_POS   = 2;
	localparam int ST_STOP_POS  = 3;
	localparam int ST_UV_POS    = 4;
	localparam int ST_PIN_POS   = 5;
	localparam int ST_LEARN_POS = 8;
	localparam int ST_EDGE_POS  = 16;

	// Startup movement thresholds in gauss (1 G per sample step)
	localparam logic [15:0] SU_NARROW_G = 16'h0028;
	localparam logic [15:0] SU_WIDE_G   = 16'h0050;

	// Percent figures of the running switch logic
	localparam logic [6:0] FRAC_LOW_PCT  = 7'h1E;
	localparam logic [6:0] FRAC_HIGH_PCT = 7'h32;
	localparam logic [6:0] DEADBAND_PCT  = 7'h0A;

	// Calibration edge counts and memory depth
	localparam logic [7:0] CAL_EDGES_ONE  = 8'h03;
	localparam logic [7:0] CAL_EDGES_FOUR = 8'h09;
	localparam logic [2:0] DEPTH_FOUR     = 3'h4;

	// Timing figures and derived cycle counts
	localparam int CLK_MHZ         = 125;
	localparam int POWERON_TIME_US = 1000;
	localparam int POWERON_CYC     = POWERON_TIME_US * CLK_MHZ;
	localparam int IDLE_TIMEOUT_S  = 5;
	localparam int IDLE_CYC        = IDLE_TIMEOUT_S * CLK_MHZ * 1000000;

	// Bus responses
	localparam logic [1:0] RESP_OKAY   = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage : tedm_pkg
`default_nettype wire

// File: rtl/tedm_top.sv
/*
 * Tooth edge decision logic: turns processed field samples into the
 * two-level open-drain output, with an AXI4-Lite register slave.
 * Assumes samples arrive on CLK_SYS, supply-good and pin readback are async.
 */
`timescale 1ns/1ns
`default_nettype none
module tedm_top #(
	parameter int ADDR_W      = 8,                       // Bus address width
	parameter int POWERON_CYC = tedm_pkg::POWERON_CYC,   // Power-on wait
	parameter int IDLE_CYC    = tedm_pkg::IDLE_CYC       // Stop-mode timeout
) (
	input  wire logic              CLK_SYS,                 // System clock
	input  wire logic              RESET,                   // Sync reset
	input  wire logic              SAMPLE_VALID,            // Sample strobe
	input  wire logic [15:0]       SAMPLE_FIELD,            // Field, offset binary
	input  wire logic              SUPPLY_OK,               // Supply above lockout
	input  wire logic              CFG_HIGH_OPPOSITE_TOOTH, // High opposite tooth
	input  wire logic              CFG_WIDE_STARTUP,        // 80 G startup
	input  wire logic              CFG_FOUR_TOOTH,          // Four-tooth memory
	input  wire logic              CFG_HALF_SWITCH,         // 50 percent point
	input  wire logic              OUT_I,                   // Output pin level
	output logic                   OUT_O,                   // Output drive value
	output logic                   OUT_OE,                  // Pull output low
	input  wire logic              AWVALID,                 // AXI write addr
	output logic                   AWREADY,                 // AXI write addr
	input  wire logic [ADDR_W-1:0] AWADDR,                  // AXI write addr
	input  wire logic              WVALID,                  // AXI write data
	output logic                   WREADY,                  // AXI write data
	input  wire logic [31:0]       WDATA,                   // AXI write data
	input  wire logic [3:0]        WSTRB,                   // AXI byte enables
	output logic                   BVALID,                  // AXI write resp
	input  wire logic              BREADY,                  // AXI write resp
	output logic [1:0]             BRESP,                   // AXI write resp
	input  wire logic              ARVALID,                 // AXI read addr
	output logic                   ARREADY,                 // AXI read addr
	input  wire logic [ADDR_W-1:0] ARADDR,                  // AXI read addr
	output logic                   RVALID,                  // AXI read data
	input  wire logic              RREADY,                  // AXI read data
	output logic [31:0]            RDATA,                   // AXI read data
	output logic [1:0]             RRESP                    // AXI read resp
);
	localparam int PO_W = $clog2(POWERON_CYC + 1);   // Power-on counter width
	localparam int ID_W = $clog2(IDLE_CYC + 1);      // Idle counter width

	// Whole state of the block
	typedef struct packed {
		tedm_pkg::tedm_mode_t mode;       // Operating mode
		logic                 sup_m;      // Supply sync, first stage
		logic                 sup_s;      // Supply sync, second stage
		logic                 pin_m;      // Pin sync, first stage
		logic                 pin_s;      // Pin sync, second stage
		logic [PO_W-1:0]      po_cnt;     // Power-on counter
		logic [ID_W-1:0]      idle_cnt;   // Cycles since last edge
		logic                 stop;       // Stop mode reached
		logic                 armed;      // Startup movement seen
		logic                 tooth;      // Tooth opposite sensor
		logic                 out_high;   // Output level
		logic [15:0]          trk_max;    // Running peak
		logic [15:0]          trk_min;    // Running valley
		logic [3:0][15:0]     mem_max;    // Stored tooth peaks
		logic [3:0][15:0]     mem_min;    // Stored valley levels
		logic [1:0]           wp;         // Next memory slot
		logic [2:0]           learned;    // Teeth learned since relearn
		logic [7:0]           edges;      // Output edges since startup
		logic                 enable;     // Sensing enabled by software
		logic                 aw_have;    // Write address held
		logic [ADDR_W-1:0]    aw_addr;    // Held write address
		logic                 w_have;     // Write data held
		logic [1:0]           w_bits;     // Held control bits
		logic                 w_lane0;    // Held lane 0 enable
		logic                 bvalid;     // Write answer pending
		logic [1:0]           bresp;      // Write answer code
		logic                 rvalid;     // Read answer pending
		logic [31:0]          rdata;      // Read answer word
		logic [1:0]           rresp;      // Read answer code
	} tedm_state_t;

	tedm_state_t s_q;   // Registered state
	tedm_state_t s_d;   // Next state

	// Percentage of a span, truncated
	function automatic logic [15:0] pct_of(input logic [15:0] span, input logic [6:0] pct);
		logic [22:0] prod;
		prod = span * pct;
		return 16'(prod / 23'd100);
	endfunction : pct_of

	// Known register word address
	function automatic logic reg_hit(input logic [ADDR_W-1:0] a);
		logic [7:0] w;
		w = {a[7:2], 2'b00};
		return (w == tedm_pkg::REG_CTRL) || (w == tedm_pkg::REG_STATUS) ||
		       (w == tedm_pkg::REG_PKPK) || (w == tedm_pkg::REG_THR);
	endfunction : reg_hit

	////////////////////////////////////////////////////////////////////////
	// Decision datapath signals
	logic        uv;         // Supply below lockout
	logic        take;       // Sample accepted
	logic        active;     // Calibrating or running
	logic        use_four;   // Reference from four teeth back
	logic [1:0]  last;       // Most recent slot
	logic [15:0] ref_max;    // Reference peak
	logic [15:0] ref_min;    // Reference valley
	logic [15:0] span;       // Reference peak-to-peak
	logic [15:0] thr;        // Switch threshold
	logic [15:0] hys;        // Half deadband
	logic [16:0] thr_hi;     // Upper switch level
	logic [16:0] thr_lo;     // Lower switch level
	logic        tooth_n;    // Tooth decision on this sample
	logic        edge_ev;    // Output edge now
	logic [15:0] nmax;       // Peak including sample
	logic [15:0] nmin;       // Valley including sample
	logic [15:0] new_span;   // Span of tooth being stored
	logic        sudden;     // Stored span jumped
	logic [7:0]  cal_edges;  // Calibration length
	logic [6:0]  frac;       // Switch fraction
	logic [15:0] su_thr;     // Startup movement needed

	// Datapath: options, reference choice, threshold and decision
	always_comb begin
		uv        = !s_q.sup_s;
		take      = SAMPLE_VALID && s_q.enable && !uv;
		active    = (s_q.mode == tedm_pkg::MODE_CALIB) || (s_q.mode == tedm_pkg::MODE_RUN);
		// Options are treated as wired straps
		frac      = CFG_HALF_SWITCH ? tedm_pkg::FRAC_HIGH_PCT : tedm_pkg::FRAC_LOW_PCT;
		su_thr    = CFG_WIDE_STARTUP ? tedm_pkg::SU_WIDE_G : tedm_pkg::SU_NARROW_G;
		cal_edges = CFG_FOUR_TOOTH ? tedm_pkg::CAL_EDGES_FOUR : tedm_pkg::CAL_EDGES_ONE;
		use_four  = CFG_FOUR_TOOTH && (s_q.learned == tedm_pkg::DEPTH_FOUR);
		last      = s_q.wp - 2'h1;
		nmax      = (SAMPLE_FIELD > s_q.trk_max) ? SAMPLE_FIELD : s_q.trk_max;
		nmin      = (SAMPLE_FIELD < s_q.trk_min) ? SAMPLE_FIELD : s_q.trk_min;
		// Startup judges on live tracking, later modes on stored teeth
		if (s_q.mode == tedm_pkg::MODE_STARTUP) begin
			ref_max = nmax;
			ref_min = nmin;
		end else if (s_q.mode == tedm_pkg::MODE_RUN && use_four) begin
			ref_max = s_q.mem_max[s_q.wp];
			ref_min = s_q.mem_min[s_q.wp];
		end else begin
			ref_max = s_q.mem_max[last];
			ref_min = s_q.mem_min[last];
		end
		span   = (ref_max > ref_min) ? ref_max - ref_min : 16'h0000;
		thr    = ref_min + pct_of(span, frac);
		// Deadband only in running mode, split evenly round the threshold
		hys    = (s_q.mode == tedm_pkg::MODE_RUN) ? (pct_of(span, tedm_pkg::DEADBAND_PCT) >> 1) :
		         16'h0000;
		thr_hi = {1'b0, thr} + {1'b0, hys};
		thr_lo = (thr > hys) ? {1'b0, thr - hys} : 17'h00000;
		tooth_n = s_q.tooth ? !({1'b0, SAMPLE_FIELD} < thr_lo) : ({1'b0, SAMPLE_FIELD} > thr_hi);
		edge_ev = take && active && (tooth_n != s_q.tooth);
		new_span = s_q.trk_max - s_q.trk_min;
		// A tooth at under half or over double the reference span counts as a jump
		sudden   = ({1'b0, new_span, 1'b0} < {2'b00, span}) || ({1'b0, new_span} > {span, 1'b0});
	end

	////////////////////////////////////////////////////////////////////////
	// Next-state logic for modes, memory, timers and the register slave
	always_comb begin
		s_d       = s_q;
		s_d.sup_m = SUPPLY_OK;
		s_d.sup_s = s_q.sup_m;
		s_d.pin_m = OUT_I;
		s_d.pin_s = s_q.pin_m;
		case (s_q.mode)
			// Wait out the power-on time with output high
			tedm_pkg::MODE_POWERON: begin
				s_d.out_high = 1'b1;
				if (s_q.po_cnt == PO_W'(POWERON_CYC - 1)) begin
					s_d.mode    = tedm_pkg::MODE_STARTUP;
					s_d.trk_max = 16'h0000;
					s_d.trk_min = 16'hFFFF;
					s_d.armed   = 1'b0;
				end else begin
					s_d.po_cnt = s_q.po_cnt + PO_W'(1);
				end
			end
			// Track movement, then fall at the first matching edge
			tedm_pkg::MODE_STARTUP: begin
				if (take) begin
					s_d.trk_max = nmax;
					s_d.trk_min = nmin;
					if (nmax > nmin && (nmax - nmin) > su_thr) begin
						s_d.armed = 1'b1;
					end
					// Output low needs tooth for low option, valley for high
					if (s_q.armed && (tooth_n != CFG_HIGH_OPPOSITE_TOOTH)) begin
						s_d.out_high   = 1'b0;
						s_d.tooth      = tooth_n;
						s_d.mode       = tedm_pkg::MODE_CALIB;
						s_d.mem_max[0] = nmax;
						s_d.mem_min[0] = nmin;
						s_d.wp         = 2'h1;
						s_d.learned    = 3'h1;
						s_d.edges      = 8'h01;
						s_d.idle_cnt   = '0;
						// Falling into a tooth keeps the valley for the record it will close
						if (!tooth_n) begin
							s_d.trk_max = SAMPLE_FIELD;
							s_d.trk_min = SAMPLE_FIELD;
						end
					end
				end
			end
			// Calibration and running share the switch path
			tedm_pkg::MODE_CALIB, tedm_pkg::MODE_RUN: begin
				if (take) begin
					s_d.trk_max = nmax;
					s_d.trk_min = nmin;
				end
				if (edge_ev) begin
					s_d.tooth    = tooth_n;
					s_d.out_high = CFG_HIGH_OPPOSITE_TOOTH ? tooth_n : !tooth_n;
					s_d.idle_cnt = '0;
					s_d.stop     = 1'b0;
					if (s_q.edges != 8'hFF) begin
						s_d.edges = s_q.edges + 8'h01;
					end
					if (s_q.mode == tedm_pkg::MODE_CALIB && s_q.edges + 8'h01 == cal_edges) begin
						s_d.mode = tedm_pkg::MODE_RUN;
					end
					// Leaving a tooth closes its record
					if (s_q.tooth) begin
						s_d.mem_max[s_q.wp] = s_q.trk_max;
						s_d.mem_min[s_q.wp] = s_q.trk_min;
						s_d.wp              = s_q.wp + 2'h1;
						s_d.trk_max         = SAMPLE_FIELD;
						s_d.trk_min         = SAMPLE_FIELD;
						if (sudden) begin
							s_d.learned = 3'h1;
						end else if (s_q.learned != tedm_pkg::DEPTH_FOUR) begin
							s_d.learned = s_q.learned + 3'h1;
						end
					end
				end else if (s_q.idle_cnt == ID_W'(IDLE_CYC - 1)) begin
					s_d.stop = 1'b1;
				end else begin
					s_d.idle_cnt = s_q.idle_cnt + ID_W'(1);
				end
			end
			default: begin
				s_d.mode = tedm_pkg::MODE_POWERON;
			end
		endcase
		// Lockout restarts from power-on with the output released high
		if (uv) begin
			s_d.mode     = tedm_pkg::MODE_POWERON;
			s_d.po_cnt   = '0;
			s_d.out_high = 1'b1;
			s_d.tooth    = 1'b0;
			s_d.stop     = 1'b0;
			s_d.idle_cnt = '0;
		end
		// Register slave: address and data taken in either order
		if (AWVALID && AWREADY) begin
			s_d.aw_have = 1'b1;
			s_d.aw_addr = AWADDR;
		end
		if (WVALID && WREADY) begin
			s_d.w_have  = 1'b1;
			s_d.w_bits  = WDATA[1:0];
			s_d.w_lane0 = WSTRB[0];
		end
		if (s_q.aw_have && s_q.w_have) begin
			s_d.aw_have = 1'b0;
			s_d.w_have  = 1'b0;
			s_d.bvalid  = 1'b1;
			s_d.bresp   = reg_hit(s_q.aw_addr) ? tedm_pkg::RESP_OKAY : tedm_pkg::RESP_SLVERR;
			if ({s_q.aw_addr[7:2], 2'b00} == tedm_pkg::REG_CTRL && s_q.w_lane0) begin
				s_d.enable = s_q.w_bits[tedm_pkg::CTRL_ENABLE_POS];
				// Relearn drops back to single-tooth reference
				if (s_q.w_bits[tedm_pkg::CTRL_RELEARN_POS]) begin
					s_d.learned = 3'h0;
				end
			end
		end else if (s_q.bvalid && BREADY) begin
			s_d.bvalid = 1'b0;
		end
		if (ARVALID && ARREADY) begin
			s_d.rvalid = 1'b1;
			s_d.rresp  = reg_hit(ARADDR) ? tedm_pkg::RESP_OKAY : tedm_pkg::RESP_SLVERR;
			s_d.rdata  = 32'h00000000;
			case ({ARADDR[7:2], 2'b00})
				tedm_pkg::REG_CTRL:   s_d.rdata[tedm_pkg::CTRL_ENABLE_POS] = s_q.enable;
				tedm_pkg::REG_STATUS: begin
					s_d.rdata[tedm_pkg::ST_MODE_POS +: 2]  = s_q.mode;
					s_d.rdata[tedm_pkg::ST_OUT_POS]        = s_q.out_high;
					s_d.rdata[tedm_pkg::ST_STOP_POS]       = s_q.stop;
					s_d.rdata[tedm_pkg::ST_UV_POS]         = uv;
					s_d.rdata[tedm_pkg::ST_PIN_POS]        = s_q.pin_s;
					s_d.rdata[tedm_pkg::ST_LEARN_POS +: 3] = s_q.learned;
					s_d.rdata[tedm_pkg::ST_EDGE_POS +: 8]  = s_q.edges;
				end
				tedm_pkg::REG_PKPK:   s_d.rdata[15:0] = span;
				tedm_pkg::REG_THR:    s_d.rdata[15:0] = thr;
				default:              s_d.rdata = 32'h00000000;
			endcase
		end else if (s_q.rvalid && RREADY) begin
			s_d.rvalid = 1'b0;
		end
	end

	// State register with synchronous reset
	always_ff @(posedge CLK_SYS) begin
		if (RESET) begin
			s_q          <= '0;
			s_q.mode     <= tedm_pkg::MODE_POWERON;
			s_q.out_high <= 1'b1;
			s_q.trk_min  <= 16'hFFFF;
			s_q.pin_m    <= 1'b1;        // Line idles high behind its pull-up
			s_q.pin_s    <= 1'b1;
			s_q.enable   <= tedm_pkg::CTRL_ENABLE_RST;
		end else begin
			s_q <= s_d;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Outputs: open drain, only ever pulls low
	assign OUT_O   = 1'b0;
	assign OUT_OE  = !s_q.out_high;
	assign AWREADY = !s_q.aw_have && !s_q.bvalid;
	assign WREADY  = !s_q.w_have && !s_q.bvalid;
	assign BVALID  = s_q.bvalid;
	assign BRESP   = s_q.bresp;
	assign ARREADY = !s_q.rvalid;
	assign RVALID  = s_q.rvalid;
	assign RDATA   = s_q.rdata;
	assign RRESP   = s_q.rresp;

	////////////////////////////////////////////////////////////////////////
	// Checks
	AST_POLARITY: assert property (@(posedge CLK_SYS) disable iff (RESET)
		$past(edge_ev) && !$past(uv) |-> OUT_OE == (CFG_HIGH_OPPOSITE_TOOTH ^ s_q.tooth))
		else $error("output level does not match polarity option");
	AST_NO_EARLY_EDGE: assert property (@(posedge CLK_SYS) disable iff (RESET)
		s_q.mode == tedm_pkg::MODE_STARTUP && !s_q.armed |=> !OUT_OE)
		else $error("edge before startup movement");
	AST_DEPTH: assert property (@(posedge CLK_SYS) disable iff (RESET)
		s_q.learned <= tedm_pkg::DEPTH_FOUR)
		else $error("learned teeth beyond memory depth");
	AST_SWITCH_LEVEL: assert property (@(posedge CLK_SYS) disable iff (RESET)
		edge_ev && tooth_n && s_q.mode == tedm_pkg::MODE_RUN |-> {1'b0, SAMPLE_FIELD} > {1'b0, thr} + {1'b0, hys})
		else $error("tooth entered inside deadband");
	AST_IDLE_STOP: assert property (@(posedge CLK_SYS) disable iff (RESET)
		active && !uv && !edge_ev && s_q.idle_cnt == ID_W'(IDLE_CYC - 1) |=> s_q.stop)
		else $error("stop mode not entered at timeout");
	AST_POWERON_HOLD: assert property (@(posedge CLK_SYS) disable iff (RESET)
		s_q.mode == tedm_pkg::MODE_POWERON |-> !OUT_OE ##1 (s_q.mode != tedm_pkg::MODE_CALIB))
		else $error("edge during power-on time");
	AST_FIRST_FALL: assert property (@(posedge CLK_SYS) disable iff (RESET)
		$past(s_q.mode) == tedm_pkg::MODE_STARTUP && s_q.mode == tedm_pkg::MODE_CALIB |-> OUT_OE)
		else $error("first edge is not high to low");
	AST_CAL_LENGTH: assert property (@(posedge CLK_SYS) disable iff (RESET)
		$past(s_q.mode) == tedm_pkg::MODE_CALIB && s_q.mode == tedm_pkg::MODE_RUN |-> s_q.edges == cal_edges)
		else $error("calibration length wrong");
	AST_UV_HIGH: assert property (@(posedge CLK_SYS) disable iff (RESET)
		uv |=> !OUT_OE [*2])
		else $error("output not high under lockout");
endmodule : tedm_top
`default_nettype wire

// File: verification/tedm_ecu_model.sv
/*
 * Controller side of the output line: pull-up resistor and edge watcher.
 * Assumes the block drives the line open drain, on the system clock.
 */
`timescale 1ns/1ns
`default_nettype none
module tedm_ecu_model (
	input  wire logic clk,       // Controller sample clock
	input  wire logic clr,       // Forget seen edges
	input  wire logic drv_val,   // Value driven by block
	input  wire logic drv_en,    // Block drives the line
	output logic      pin,       // Line level
	output logic      seen,      // An edge was seen
	output logic      first_fall // First edge was a fall
);
	logic prev; // Line level one clock earlier

	////////////////////////////////////////////////////////////////////////
	// Pull-up holds the line high whenever the block lets go
	assign pin = drv_en ? drv_val : 1'b1;

	// Direction of the first edge since clear; later edges are ignored
	always_ff @(posedge clk) begin
		prev <= pin;
		if (clr) begin
			seen       <= 1'b0;
			first_fall <= 1'b0;
		end else if (!seen && pin != prev) begin
			seen       <= 1'b1;
			first_fall <= !pin;
		end
	end
endmodule : tedm_ecu_model
`default_nettype wire

// File: verification/tb_tooth_edge_detector_modes.sv
/*
 * Self-checking bench of the tooth edge decision block, four option sets.
 * Assumes shortened power-on and idle counts and the controller model.
 */
`timescale 1ns/1ns
`default_nettype none
module tb_tooth_edge_detector_modes;
	localparam int PO  = 40;  // Short power-on count keeps the run brief
	localparam int IDL = 200; // Short idle count
	logic        clk, rst, s_vld, s_ok, ho, wide, four, half, eclr; // Clock, reset, sample side
	logic [15:0] s_fld, su, thr;                // Sample, startup step, threshold
	logic        awv, wv, bry, arv, rry;        // Bus requests
	logic        awr, wrdy, bv, arr, rv;        // Bus answers
	logic [7:0]  awa, ara;                      // Bus addresses
	logic [31:0] wd, rdt;                       // Bus data
	logic [1:0]  brs, rrs, e_b;                 // Responses
	logic        out_o, out_oe, pin, seen, ffall; // Output line
	logic [65:0] aq[$];                         // Expected reads: mask, data, resp
	logic [1:0]  bq[$];                         // Expected write responses
	logic [65:0] e_a;                           // Oldest read note
	int          err_total, compares, k;        // Counters, option index

	////////////////////////////////////////////////////////////////////////
	tedm_top #(.POWERON_CYC(PO), .IDLE_CYC(IDL)) i_dut (.CLK_SYS(clk), .RESET(rst),
		.SAMPLE_VALID(s_vld), .SAMPLE_FIELD(s_fld), .SUPPLY_OK(s_ok), .CFG_HIGH_OPPOSITE_TOOTH(ho),
		.CFG_WIDE_STARTUP(wide), .CFG_FOUR_TOOTH(four), .CFG_HALF_SWITCH(half), .OUT_I(pin),
		.OUT_O(out_o), .OUT_OE(out_oe), .AWVALID(awv), .AWREADY(awr), .AWADDR(awa), .WVALID(wv),
		.WREADY(wrdy), .WDATA(wd), .WSTRB(4'hF), .BVALID(bv), .BREADY(bry), .BRESP(brs),
		.ARVALID(arv), .ARREADY(arr), .ARADDR(ara), .RVALID(rv), .RREADY(rry), .RDATA(rdt), .RRESP(rrs));
	tedm_ecu_model i_ecu (.clk(clk), .clr(eclr), .drv_val(out_o), .drv_en(out_oe), .pin(pin),
		.seen(seen), .first_fall(ffall));

	////////////////////////////////////////////////////////////////////////
	// Clock and hang guard
	initial begin
		clk = 1'b0;
		forever #4 clk = ~clk;
	end
	initial begin
		repeat (100000) @(posedge clk);
		err_total++;
		test_done();
	end

	// Verdict and end of run
	task automatic test_done;
		$display("compares %0d mismatches %0d", compares, err_total);
		if (err_total == 0 && compares > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask : test_done

	task automatic cmp_val(input logic [31:0] g, input logic [31:0] x);
		compares++;
		if (g !== x) begin
			err_total++;
			$display("BAD t=%0t got %h exp %h", $time, g, x);
		end
	endtask : cmp_val

	task automatic cmp_lvl(input logic g, input logic x);
		compares++;
		if (g !== x) begin
			err_total++;
			$display("BAD t=%0t got %h exp %h", $time, g, x);
		end
	endtask : cmp_lvl

	// A used-up wait counts as a mismatch and ends the run
	task automatic tmo(input int n);
		if (n >= 50) begin
			err_total++;
			test_done();
		end
	endtask : tmo

	// Wait n edges, then settle past the edge
	task automatic at(input int n);
		repeat (n) @(posedge clk);
		#1;
	endtask : at

	task automatic smp(input logic [15:0] v);
		@(posedge clk);
		s_vld <= 1'b1;
		s_fld <= v;
	endtask : smp

	task automatic quiet;
		@(posedge clk);
		s_vld <= 1'b0;
	endtask : quiet

	task automatic pulse(input logic [15:0] v);
		smp(v);
		quiet();
	endtask : pulse

	// Back-to-back samples, three per tooth and three per valley
	task automatic teeth(input int n);
		repeat (n) begin
			repeat (3) smp(16'h044C);
			repeat (3) smp(16'h0064);
		end
		quiet();
	endtask : teeth

	// Write: address and data together, each dropped once taken
	task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r);
		int n;
		bq.push_back(r);
		@(posedge clk);
		awv <= 1'b1;
		awa <= a;
		wv  <= 1'b1;
		wd  <= d;
		bry <= 1'b1;
		for (n = 0; n < 50; n++) begin
			@(posedge clk);
			if (awv && awr) awv <= 1'b0;
			if (wv && wrdy) wv <= 1'b0;
			if (bv) break;
		end
		bry <= 1'b0;
		tmo(n);
	endtask : wr

	task automatic rd(input logic [7:0] a, input logic [31:0] m, input logic [31:0] x, input logic [1:0] r);
		int n;
		aq.push_back({m, x, r});
		@(posedge clk);
		arv <= 1'b1;
		ara <= a;
		rry <= 1'b1;
		for (n = 0; n < 50; n++) begin
			@(posedge clk);
			if (arv && arr) arv <= 1'b0;
			if (rv) break;
		end
		rry <= 1'b0;
		tmo(n);
	endtask : rd

	// Answer watcher: each answer is held against the oldest note
	always @(posedge clk) begin
		if (rv && rry) begin
			e_a = aq.pop_front();
			cmp_val(rdt & e_a[65:34], e_a[33:2]);
			cmp_val({30'h0, rrs}, {30'h0, e_a[1:0]});
		end
		if (bv && bry) begin
			e_b = bq.pop_front();
			cmp_val({30'h0, brs}, {30'h0, e_b});
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Main sequence over four option sets
	initial begin
		{rst, s_ok, eclr} = 3'h7;
		{s_vld, awv, wv, bry, arv, rry, ho, wide, four, half} = '0;
		{s_fld, awa, ara, wd} = '0;
		err_total = 0;
		compares = 0;
		void'($urandom(32'hca4ec080));
		for (k = 0; k < 4; k++) begin
			@(posedge clk);
			rst  <= 1'b1;
			s_ok <= 1'b1;
			eclr <= 1'b1;
			{ho, wide} <= k[1:0];
			four <= k[0] ^ k[1];
			half <= k[1];
			repeat (10) @(posedge clk);
			rst  <= 1'b0;
			eclr <= 1'b0;
			su  = wide ? 16'h0050 : 16'h0028;
			thr = half ? 16'h0258 : 16'h0190;
			rd(8'h04, 32'h27, 32'h24, 2'h0);
			rd(8'h00, 32'h3, 32'h1, 2'h0);
			teeth(1);
			at(1);
			cmp_lvl(seen, 1'b0);
			at(PO + 10);
			rd(8'h04, 32'h3, 32'h1, 2'h0);
			repeat (4) begin
				smp(16'h01F4);
				smp(16'h01F4 + su - 16'h0005);
			end
			quiet();
			at(3);
			cmp_lvl(seen, 1'b0);
			teeth(1);
			at(3);
			cmp_lvl(ffall, 1'b1);
			teeth(2);
			rd(8'h04, 32'hFF0003, {8'h0, ho ? 8'h05 : 8'h06, 14'h0, four ? 2'h2 : 2'h3}, 2'h0);
			teeth(4);
			rd(8'h04, 32'h3, 32'h3, 2'h0);
			rd(8'h08, 32'hFFFF, 32'h03E8, 2'h0);
			rd(8'h0C, 32'hFFFF, {16'h0, thr}, 2'h0);
			pulse(16'h044C);
			at(3);
			cmp_lvl(out_oe, !ho);
			pulse(16'h0064);
			at(3);
			cmp_lvl(out_oe, ho);
			pulse(thr + 16'($urandom_range(0, 45)));
			at(3);
			cmp_lvl(out_oe, ho);
			pulse(thr + 16'(55 + $urandom_range(0, 40)));
			at(3);
			cmp_lvl(out_oe, !ho);
			rd(8'h04, 32'h8, 32'h0, 2'h0);
			at(IDL + 10);
			rd(8'h04, 32'h8, 32'h8, 2'h0);
			wr(8'h00, 32'h3, 2'h0);
			rd(8'h00, 32'h3, 32'h1, 2'h0);
			rd(8'h04, 32'h700, 32'h0, 2'h0);
			wr(8'h10, 32'h1, 2'h2);
			rd(8'h10, 32'hFFFFFFFF, 32'h0, 2'h2);
			// Sensing switched off: a valley sample must leave the level alone
			wr(8'h00, 32'h0, 2'h0);
			pulse(16'h0064);
			at(3);
			cmp_lvl(out_oe, !ho);
			wr(8'h00, 32'h1, 2'h0);
			pulse(ho ? 16'h0064 : 16'h044C);
			at(3);
			cmp_lvl(out_oe, 1'b1);
			@(posedge clk);
			s_ok <= 1'b0;
			at(5);
			cmp_lvl(out_oe, 1'b0);
			teeth(1);
			at(3);
			cmp_lvl(pin, 1'b1);
			rd(8'h04, 32'h13, 32'h10, 2'h0);
			@(posedge clk);
			s_ok <= 1'b1;
			at(PO + 10);
			rd(8'h04, 32'h13, 32'h01, 2'h0);
			$display("option set %0d done", k);
		end
		test_done();
	end
endmodule : tb_tooth_edge_detector_modes
`default_nettype wire
